//--- rtl/ovd_consts.vh
// Constants of the three-phase definite-time overvoltage detector
//
// Contract
// - The block takes three fundamental RMS voltages (phase or line-pair) plus its settings.
// - A phase picks up when its voltage is above the pickup level, 30 to 130 percent, default 110.
// - A picked-up phase drops only when at least the dropout margin (1-10, default 5) below level, or when the function is inactive.
// - The block times a delay of 0 to 60000 ms (default 100) while a phase is picked up.
// - Each phase has a pickup and an expired status; expired only after its delay while picked up.
// - An enable setting, off by default, forces every pickup and trip output inactive when off.
// - An inhibit input from outside logic disables the function while it is asserted.
// - The overall trip combines per-phase pickup and expired states with the pickup-only setting.
// - Per-phase expired flags stay internal; three pickups, any-pickup and overall trip go out.
// - With line-pair mode selected the three channels stand for the three line pairs.
// - Any-phase pickup is high, one clock later, whenever any channel is picked up while the function is active.
`ifndef OVD_CONSTS_VH
`define OVD_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_CTRL 12'h000
`define OFF_PICKUP 12'h004
`define OFF_MARGIN 12'h008
`define OFF_DELAY 12'h00C
`define OFF_STATUS 12'h010
`define OFF_IRQ_STAT 12'h014
`define OFF_IRQ_CLR 12'h018
`define OFF_IRQ_EN 12'h01C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_PICKUP_ONLY_BIT 1
`define CTRL_LINE_PAIR_BIT 2
`define IRQ_TRIP_BIT 3
`define STAT_ANY_BIT 3
`define STAT_TRIP_BIT 4
`define STAT_INHIBIT_BIT 5
`define STAT_LINE_PAIR_BIT 6

// ----------------------------------------------------------------
// Reset values and setting ranges
// ----------------------------------------------------------------
`define RST_PICKUP 8'h6E
`define MIN_PICKUP 8'h1E
`define MAX_PICKUP 8'h82
`define RST_MARGIN 4'h5
`define MIN_MARGIN 4'h1
`define MAX_MARGIN 4'hA
`define RST_DELAY 16'h0064
`define MAX_DELAY 16'hEA60
`define RMS_PER_PERCENT 16'h000A

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define TIME_BASE_NS 1000000
`define TICK_CYCLES (`TIME_BASE_NS / `CLK_PERIOD_NS)

`endif

//--- rtl/overvoltage_function.v
// Top of the three-phase definite-time overvoltage detector with APB registers
`timescale 1ns/10ps
`default_nettype none
`include "ovd_consts.vh"

module overvoltage_function #(
	parameter integer TICK_CYCLES = `TICK_CYCLES
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [15:0] phase1_fundamental_rms,
	input wire [15:0] phase2_fundamental_rms,
	input wire [15:0] phase3_fundamental_rms,
	input wire inhibit_input,
	output wire phase1_pickup,
	output wire phase2_pickup,
	output wire phase3_pickup,
	output reg any_phase_pickup,
	output reg overall_trip,
	output reg irq
);

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg function_enable_setting;
reg pickup_only_setting;
reg line_pair_mode;
reg [7:0] pickup_level_setting;
reg [3:0] dropout_margin_setting;
reg [15:0] trip_delay_setting;
reg [3:0] irq_stat_reg;
reg [3:0] irq_en_reg;
reg [3:0] irq_stat_next;
reg inhibit_meta_reg;
reg inhibit_sync_reg;
reg [31:0] tick_count_reg;
reg ms_tick_reg;
reg [2:0] pickup_prev_reg;
reg trip_prev_reg;
reg [31:0] read_value;
reg addr_ok;
reg [7:0] wr_pickup;
reg [3:0] wr_margin;
reg [15:0] wr_delay;
wire [15:0] level_on;
wire [15:0] level_off;
wire [47:0] rms_bus;
wire [2:0] pickup_vec;
wire [2:0] expired_vec;
wire active;
wire setup_phase;
wire access_phase;
wire wr_access;
wire trip_next;
wire [3:0] events;

// ----------------------------------------------------------------
// Bus phases
// ----------------------------------------------------------------
// Zero-wait slave: read data is captured in the setup cycle
assign setup_phase = psel && !penable;
assign access_phase = psel && penable;
assign wr_access = access_phase && pwrite && addr_ok;
assign pready = 1'b1;
assign pslverr = access_phase && !addr_ok;

// Address decode for mapped words
always @* begin
	if (paddr == `OFF_CTRL) begin
		addr_ok = 1'b1;
	end else if (paddr == `OFF_PICKUP) begin
		addr_ok = 1'b1;
	end else if (paddr == `OFF_MARGIN) begin
		addr_ok = 1'b1;
	end else if (paddr == `OFF_DELAY) begin
		addr_ok = 1'b1;
	end else if (paddr == `OFF_STATUS) begin
		addr_ok = 1'b1;
	end else if (paddr == `OFF_IRQ_STAT) begin
		addr_ok = 1'b1;
	end else if (paddr == `OFF_IRQ_CLR) begin
		addr_ok = 1'b1;
	end else if (paddr == `OFF_IRQ_EN) begin
		addr_ok = 1'b1;
	end else begin
		addr_ok = 1'b0;
	end
end

// ----------------------------------------------------------------
// Read multiplexer
// ----------------------------------------------------------------
// Clear register reads as zero, unmapped words read as zero
always @* begin
	read_value = 32'h00000000;
	if (paddr == `OFF_CTRL) begin
		read_value[`CTRL_ENABLE_BIT] = function_enable_setting;
		read_value[`CTRL_PICKUP_ONLY_BIT] = pickup_only_setting;
		read_value[`CTRL_LINE_PAIR_BIT] = line_pair_mode;
	end else if (paddr == `OFF_PICKUP) begin
		read_value[7:0] = pickup_level_setting;
	end else if (paddr == `OFF_MARGIN) begin
		read_value[3:0] = dropout_margin_setting;
	end else if (paddr == `OFF_DELAY) begin
		read_value[15:0] = trip_delay_setting;
	end else if (paddr == `OFF_STATUS) begin
		read_value[2:0] = pickup_vec;
		read_value[`STAT_ANY_BIT] = any_phase_pickup;
		read_value[`STAT_TRIP_BIT] = overall_trip;
		read_value[`STAT_INHIBIT_BIT] = inhibit_sync_reg;
		read_value[`STAT_LINE_PAIR_BIT] = line_pair_mode;
	end else if (paddr == `OFF_IRQ_STAT) begin
		read_value[3:0] = irq_stat_reg;
	end else if (paddr == `OFF_IRQ_EN) begin
		read_value[3:0] = irq_en_reg;
	end
end

// Registered read data
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h00000000;
	end else if (setup_phase && !pwrite) begin
		prdata <= read_value;
	end
end

// ----------------------------------------------------------------
// Setting write values clamped to their legal ranges
// ----------------------------------------------------------------
always @* begin
	if (pwdata[31:8] != 24'h000000 || pwdata[7:0] > `MAX_PICKUP) begin
		wr_pickup = `MAX_PICKUP;
	end else if (pwdata[7:0] < `MIN_PICKUP) begin
		wr_pickup = `MIN_PICKUP;
	end else begin
		wr_pickup = pwdata[7:0];
	end
	if (pwdata[31:4] != 28'h0000000 || pwdata[3:0] > `MAX_MARGIN) begin
		wr_margin = `MAX_MARGIN;
	end else if (pwdata[3:0] < `MIN_MARGIN) begin
		wr_margin = `MIN_MARGIN;
	end else begin
		wr_margin = pwdata[3:0];
	end
	if (pwdata[31:16] != 16'h0000 || pwdata[15:0] > `MAX_DELAY) begin
		wr_delay = `MAX_DELAY;
	end else begin
		wr_delay = pwdata[15:0];
	end
end

// ----------------------------------------------------------------
// Setting registers
// ----------------------------------------------------------------
// Writes take effect at the access edge only
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		function_enable_setting <= 1'b0;
		pickup_only_setting <= 1'b0;
		line_pair_mode <= 1'b0;
		pickup_level_setting <= `RST_PICKUP;
		dropout_margin_setting <= `RST_MARGIN;
		trip_delay_setting <= `RST_DELAY;
		irq_en_reg <= 4'h0;
	end else if (wr_access) begin
		if (paddr == `OFF_CTRL) begin
			function_enable_setting <= pwdata[`CTRL_ENABLE_BIT];
			pickup_only_setting <= pwdata[`CTRL_PICKUP_ONLY_BIT];
			line_pair_mode <= pwdata[`CTRL_LINE_PAIR_BIT];
		end else if (paddr == `OFF_PICKUP) begin
			pickup_level_setting <= wr_pickup;
		end else if (paddr == `OFF_MARGIN) begin
			dropout_margin_setting <= wr_margin;
		end else if (paddr == `OFF_DELAY) begin
			trip_delay_setting <= wr_delay;
		end else if (paddr == `OFF_IRQ_EN) begin
			irq_en_reg <= pwdata[3:0];
		end
	end
end

// ----------------------------------------------------------------
// Inhibit pin synchroniser
// ----------------------------------------------------------------
// Two flops, only the second one is looked at
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		inhibit_meta_reg <= 1'b0;
		inhibit_sync_reg <= 1'b0;
	end else begin
		inhibit_meta_reg <= inhibit_input;
		inhibit_sync_reg <= inhibit_meta_reg;
	end
end

// Function runs only when enabled and not inhibited
assign active = function_enable_setting && !inhibit_sync_reg;

// ----------------------------------------------------------------
// Millisecond time base
// ----------------------------------------------------------------
// One-cycle enable every TICK_CYCLES clocks
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		tick_count_reg <= 32'h00000000;
		ms_tick_reg <= 1'b0;
	end else if (tick_count_reg >= TICK_CYCLES - 1) begin
		tick_count_reg <= 32'h00000000;
		ms_tick_reg <= 1'b1;
	end else begin
		tick_count_reg <= tick_count_reg + 32'h00000001;
		ms_tick_reg <= 1'b0;
	end
end

// ----------------------------------------------------------------
// Thresholds in RMS units (tenths of a percent of nominal)
// ----------------------------------------------------------------
assign level_on = {8'h00, pickup_level_setting} * `RMS_PER_PERCENT;
assign level_off = ({8'h00, pickup_level_setting} - {12'h000, dropout_margin_setting})
	* `RMS_PER_PERCENT;

// Channel inputs: phases or line pairs as the upstream stage delivers
assign rms_bus = {phase3_fundamental_rms, phase2_fundamental_rms,
	phase1_fundamental_rms};

// ----------------------------------------------------------------
// Measuring channels
// ----------------------------------------------------------------
genvar ch;
generate
	for (ch = 0; ch < 3; ch = ch + 1) begin : g_channel
		phase_channel u_channel (
			.pclk(pclk),
			.presetn(presetn),
			.rms(rms_bus[ch*16 +: 16]),
			.level_on(level_on),
			.level_off(level_off),
			.delay_ms(trip_delay_setting),
			.ms_tick(ms_tick_reg),
			.active(active),
			.pickup_reg(pickup_vec[ch]),
			.expired_reg(expired_vec[ch])
		);
	end
endgenerate

// ----------------------------------------------------------------
// Decision logic
// ----------------------------------------------------------------
// Expired flags never leave the block
assign phase1_pickup = pickup_vec[0];
assign phase2_pickup = pickup_vec[1];
assign phase3_pickup = pickup_vec[2];
assign trip_next = active && !pickup_only_setting && |(expired_vec & pickup_vec);

// General outputs registered
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		any_phase_pickup <= 1'b0;
		overall_trip <= 1'b0;
	end else begin
		any_phase_pickup <= active && |pickup_vec;
		overall_trip <= trip_next;
	end
end

// ----------------------------------------------------------------
// Interrupt status, enable and clear
// ----------------------------------------------------------------
// Events: rising pickup per phase and rising overall trip
assign events = {overall_trip && !trip_prev_reg, pickup_vec & ~pickup_prev_reg};

// Set wins over a clear in the same cycle
always @* begin
	irq_stat_next = irq_stat_reg;
	if (wr_access && paddr == `OFF_IRQ_CLR) begin
		irq_stat_next = irq_stat_next & ~pwdata[3:0];
	end
	irq_stat_next = irq_stat_next | events;
end

// Event edge memory, sticky status and level interrupt
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pickup_prev_reg <= 3'h0;
		trip_prev_reg <= 1'b0;
		irq_stat_reg <= 4'h0;
		irq <= 1'b0;
	end else begin
		pickup_prev_reg <= pickup_vec;
		trip_prev_reg <= overall_trip;
		irq_stat_reg <= irq_stat_next;
		irq <= |(irq_stat_next & irq_en_reg);
	end
end

endmodule // overvoltage_function

`default_nettype wire

//--- rtl/phase_channel.v
// One measuring channel: pickup with dropout margin and definite-delay timer
`timescale 1ns/10ps
`default_nettype none

module phase_channel (
	input wire pclk,
	input wire presetn,
	input wire [15:0] rms,
	input wire [15:0] level_on,
	input wire [15:0] level_off,
	input wire [15:0] delay_ms,
	input wire ms_tick,
	input wire active,
	output reg pickup_reg,
	output reg expired_reg
);

reg [15:0] count_reg;
reg pickup_next;

// Pickup decision with hysteresis
always @* begin
	if (!active) begin
		pickup_next = 1'b0;
	end else if (!pickup_reg) begin
		pickup_next = (rms > level_on);
	end else begin
		pickup_next = !(rms <= level_off);
	end
end

// Pickup flag, delay timer and expired flag
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pickup_reg <= 1'b0;
		count_reg <= 16'h0000;
		expired_reg <= 1'b0;
	end else begin
		pickup_reg <= pickup_next;
		if (!pickup_reg || !active) begin
			count_reg <= 16'h0000;
		end else if (ms_tick && (count_reg < delay_ms)) begin
			count_reg <= count_reg + 16'h0001;
		end
		expired_reg <= active && pickup_reg && pickup_next && (count_reg >= delay_ms);
	end
end

endmodule // phase_channel

`default_nettype wire

//--- tb/ovd_props.sv
// Port-level assertions of the overvoltage detector
`timescale 1ns/10ps
`default_nettype none
`include "ovd_consts.vh"

module ovd_props #(
	parameter integer TICK_CYCLES = 50000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic [15:0] phase1_fundamental_rms,
	input wire logic inhibit_input,
	input wire logic phase1_pickup,
	input wire logic phase2_pickup,
	input wire logic phase3_pickup,
	input wire logic any_phase_pickup,
	input wire logic overall_trip,
	input wire logic irq
);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Any channel picked up
	wire any_now = phase1_pickup | phase2_pickup | phase3_pickup;
	sequence s_inhib; inhibit_input [*4]; endsequence
	sequence s_off; psel && penable && pwrite && paddr == `OFF_CTRL && !pwdata[0]; endsequence
	sequence s_mask; psel && penable && pwrite && paddr == `OFF_IRQ_EN && pwdata[3:0] == 4'h0; endsequence
	sequence s_quiet; !any_now [*2]; endsequence
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("slave error outside access");
	property p_any; any_phase_pickup |-> $past(any_now); endproperty
	a_any: assert property (p_any) else $error("any pickup without a channel pickup");
	property p_gen; any_now && $past(any_now) |-> any_phase_pickup; endproperty
	a_gen: assert property (p_gen) else $error("any pickup missing while picked up");
	property p_trip; overall_trip |-> $past(any_now); endproperty
	a_trip: assert property (p_trip) else $error("trip without pickup");
	property p_fall; s_quiet |-> !overall_trip; endproperty
	a_fall: assert property (p_fall) else $error("trip held after dropout");
	property p_inh; s_inhib |-> !any_now ##1 !any_phase_pickup && !overall_trip; endproperty
	a_inh: assert property (p_inh) else $error("outputs active while inhibited");
	property p_off; s_off |=> ##1 !any_now; endproperty
	a_off: assert property (p_off) else $error("pickup after disable");
	property p_low; (phase1_fundamental_rms <= 16'h00C8) [*2] |-> !phase1_pickup; endproperty
	a_low: assert property (p_low) else $error("pickup on low voltage");
	property p_mask; s_mask |=> ##1 !irq; endproperty
	a_mask: assert property (p_mask) else $error("irq with all sources masked");
endmodule // ovd_props

bind overvoltage_function ovd_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pslverr(pslverr), .phase1_fundamental_rms(phase1_fundamental_rms),
	.inhibit_input(inhibit_input), .phase1_pickup(phase1_pickup),
	.phase2_pickup(phase2_pickup), .phase3_pickup(phase3_pickup),
	.any_phase_pickup(any_phase_pickup), .overall_trip(overall_trip), .irq(irq));
`default_nettype wire

//--- tb/overvoltage_function_bench.sv
// Self-checking bench of the overvoltage detector
`timescale 1ns/10ps
`default_nettype none
`include "ovd_consts.vh"

module overvoltage_function_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, inhibit_input = 0, slow = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [15:0] t1 = 0, t2 = 0, t3 = 0, r1, r2, r3;
	logic pready, pslverr, err, p1, p2, p3, anyp, trip, irq;
	int bad_count = 0, comparisons = 0, cyc = 0;
	localparam logic [11:0] RA [5] = '{`OFF_CTRL, `OFF_PICKUP, `OFF_MARGIN, `OFF_DELAY, `OFF_IRQ_EN};
	localparam logic [31:0] RV [5] = '{0, `RST_PICKUP, `RST_MARGIN, `RST_DELAY, 0};
	localparam logic [11:0] CA [5] = '{`OFF_PICKUP, `OFF_PICKUP, `OFF_MARGIN, `OFF_MARGIN, `OFF_DELAY};
	localparam logic [31:0] CW [5] = '{32'h14, 32'h96, 32'h0, 32'hF, 32'hFFFF};
	localparam logic [31:0] CE [5] = '{32'h1E, 32'h82, 32'h1, 32'hA, 32'hEA60};
	// ----------------------------------------------------------------
	// Clock, design, partner and timeout
	// ----------------------------------------------------------------
	initial begin
		forever #10 pclk = ~pclk;
	end
	overvoltage_function #(.TICK_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .phase1_fundamental_rms(r1),
		.phase2_fundamental_rms(r2), .phase3_fundamental_rms(r3), .inhibit_input(inhibit_input),
		.phase1_pickup(p1), .phase2_pickup(p2), .phase3_pickup(p3), .any_phase_pickup(anyp),
		.overall_trip(trip), .irq(irq));
	rms_source i_src (.pclk(pclk), .slow(slow), .t1(t1), .t2(t2), .t3(t3), .r1(r1), .r2(r2),
		.r3(r3));
	// Cuts a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count++;
			report_and_stop();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer, held until pready, then one idle cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int i = 0; i < 5; i++) begin
			apb(0, RA[i], 0);
			chk("reset value", rd, RV[i]);
		end
		for (int i = 0; i < 5; i++) begin
			apb(1, CA[i], CW[i]);
			apb(0, CA[i], 0);
			chk("clamped setting", rd, CE[i]);
		end
		apb(0, 12'h020, 0);
		chk("unmapped error", err, 1);
		chk("unmapped data", rd, 0);
		apb(1, `OFF_PICKUP, 100);
		apb(1, `OFF_MARGIN, 5);
		apb(1, `OFF_DELAY, 3);
		apb(1, `OFF_IRQ_EN, 32'hF);
		t1 <= 1200;
		w(6);
		chk("pickup while off", p1, 0);
		t1 <= 1000;
		apb(1, `OFF_CTRL, 1);
		w(6);
		chk("pickup at level", p1, 0);
		t1 <= 1001;
		w(3);
		chk("pickup above level", p1, 1);
		w(2);
		chk("any pickup", anyp, 1);
		w(15);
		chk("trip early", trip, 0);
		w(25);
		chk("trip after delay", trip, 1);
		t1 <= 951;
		w(4);
		chk("held inside margin", p1, 1);
		t1 <= 950;
		w(4);
		chk("dropout", p1, 0);
		chk("trip after dropout", trip, 0);
		t1 <= 1200;
		w(18);
		chk("timer restarted", trip, 0);
		w(25);
		chk("trip again", trip, 1);
		inhibit_input <= 1;
		w(6);
		chk("pickup inhibited", p1, 0);
		chk("trip inhibited", trip, 0);
		inhibit_input <= 0;
		w(4);
		chk("pickup released", p1, 1);
		w(40);
		chk("irq raised", irq, 1);
		apb(0, `OFF_IRQ_STAT, 0);
		chk("irq status", rd, 32'h9);
		t1 <= 0;
		w(4);
		apb(1, `OFF_IRQ_CLR, 32'hF);
		w(2);
		chk("irq cleared", irq, 0);
		apb(1, `OFF_IRQ_EN, 0);
		t2 <= 1200;
		w(6);
		chk("phase2 pickup", p2, 1);
		chk("irq masked", irq, 0);
		apb(0, `OFF_IRQ_STAT, 0);
		chk("masked status", rd, 32'h2);
		apb(1, `OFF_CTRL, 7);
		slow <= 1;
		t2 <= 0;
		t3 <= 1200;
		w(120);
		chk("phase3 pickup", p3, 1);
		chk("pickup only", trip, 0);
		apb(0, `OFF_STATUS, 0);
		chk("status", rd[6:0], 7'h4C);
		apb(1, `OFF_CTRL, 0);
		w(4);
		chk("disabled", p3, 0);
		chk("any disabled", anyp, 0);
		report_and_stop();
	end
endmodule // overvoltage_function_bench
`default_nettype wire

//--- tb/rms_source.sv
// Upstream stage model giving one fundamental RMS value per channel
`timescale 1ns/10ps
`default_nettype none

module rms_source (
	input wire logic pclk,
	input wire logic slow,
	input wire logic [15:0] t1,
	input wire logic [15:0] t2,
	input wire logic [15:0] t3,
	output logic [15:0] r1,
	output logic [15:0] r2,
	output logic [15:0] r3
);
	// Slow mode settles in steps, like a filter window filling
	function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] t, input logic s);
		if (!s || (c > t ? c - t : t - c) <= 16'h0010)
			return t;
		return c > t ? c - 16'h0010 : c + 16'h0010;
	endfunction
	// New estimate on every clock, phase or line-pair alike; fast mode jumps to target
	always @(posedge pclk) begin
		r1 <= step(r1, t1, slow);
		r2 <= step(r2, t2, slow);
		r3 <= step(r3, t3, slow);
	end
endmodule // rms_source
`default_nettype wire
